// ---- shared/cs_pkg.sv ----
// constants for the lower, mid-range and peripheral chip-select decoder
package cs_pkg;

  // control block offsets of the four select registers
  localparam logic [7:0] OFS_LOWER_MEMORY_LIMIT = 8'hA2;
  localparam logic [7:0] OFS_PERIPHERAL_BASE_READY = 8'hA4;
  localparam logic [7:0] OFS_MIDRANGE_BASE_READY = 8'hA6;
  localparam logic [7:0] OFS_MIDRANGE_SIZE_PERIPH_MODE = 8'hA8;

  // register contents are undefined after reset; zero is used so state is known
  localparam logic [15:0] REG_RESET_VALUE = 16'h0000;

  // ready_mode_field position, shared by all four registers
  localparam int READY_LSB = 0;
  localparam int READY_MSB = 2;
  // top bit of a ready field: set means external ready is ignored
  localparam int READY_IGNORE_BIT = 2;

  // lower limit field: register bits 15..6 against address bits 19..10
  localparam int LOWER_LIMIT_LSB = 6;
  localparam int LOWER_LIMIT_MSB = 15;
  // low register bits taken as ones when comparing
  localparam logic [5:0] LOWER_FILL_ONES = 6'h3F;

  // mid-range base field: register bits 15..9 give address bits 19..13
  localparam int MID_BASE_LSB = 9;
  localparam int MID_BASE_MSB = 15;
  // mid-range one-hot size field, bits 14..8, 8K at bit 8 up to 512K at bit 14
  localparam int MID_SIZE_LSB = 8;
  localparam int MID_SIZE_MSB = 14;
  localparam int MID_SIZE_COUNT = 7;
  // address bit where the smallest (8K) total block begins
  localparam int MID_BLOCK_SHIFT = 13;
  localparam int MID_SELECT_COUNT = 4;

  // peripheral base field: register bits 15..6 give address bits 19..10
  localparam int PERI_BASE_LSB = 6;
  localparam int PERI_BASE_MSB = 15;
  localparam int PERI_SELECT_COUNT = 7;
  // lines from this index up take their ready mode from the mid-range size register
  localparam int PERI_UPPER_GROUP = 4;
  // bits of the mid-range size register that steer the peripheral selects
  localparam int EXTEND_SELECT_COUNT_BIT = 7;
  localparam int PERIPH_SPACE_SELECT_BIT = 6;
  // lines replaced by latched A1 and A2 when extend_select_count is clear
  localparam int PERI_A1_LINE = 5;
  localparam int PERI_A2_LINE = 6;

endpackage : cs_pkg

// ---- logic/lower_mid_periph_chip_select.sv ----
// chip-select decoder for the lower, mid-range and peripheral address ranges
`timescale 1ns/1ps

// Summary of operation
// - lower range always starts at address zero
// - lower limit encodes 1K to 256K blocks
// - lower select idle until its register accessed
// - lower hit when upper address bits at or below limit
// - lower register low bits give ready mode
// - one-hot size field sets mid-range block size
// - mid block split into four equal quarters
// - base bits give A19..A13, low bits zero
// - mid selects idle until both registers accessed
// - mid base ready bits cover all four lines
// - seven peripheral selects of 128 bytes each
// - peripheral base bits give address bits 19..10
// - line n covers base plus 128n block
// - extend clear makes lines five, six latched A1/A2
// - space bit picks memory or I/O peripherals
// - peripheral selects idle until both registers accessed
// - ready mode split between lines 0-3, 4-6
// - ready field gives waits and external ready use
// - selects follow CPU and DMA cycles alike
// - all selects inactive high during reset
module lower_mid_periph_chip_select
  import cs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  // control block register port
  input wire logic reg_sel,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // bus cycle address phase, from the core or the DMA unit
  input wire logic cyc_valid,
  input wire logic cyc_is_mem,
  input wire logic [19:0] cyc_addr,
  // select outputs, active low
  output logic low_mem_select_n,
  output logic [3:0] midrange_select_n,
  output logic [6:0] peripheral_select_n,
  // ready mode of the range hit by the current cycle
  output logic ready_valid,
  output logic [2:0] ready_mode_field,
  output logic [1:0] wait_states,
  output logic ext_ready_used
);

  // stored register images
  // software sees no defined value after reset; they clear to zero here only
  // to keep the model free of unknowns, and the access flags below, not these
  // values, keep the selects dark
  logic [15:0] lower_memory_limit_r; // upper limit and ready mode of lower range
  logic [15:0] peripheral_base_ready_r; // peripheral base and ready for lines 0-3
  logic [15:0] midrange_base_ready_r; // mid-range base and ready mode
  logic [15:0] midrange_size_periph_mode_r; // mid size, extend, space, ready 4-6

  // one flag per register, set by the first read or write after reset
  // the mid-range size flag gates both the mid-range and the peripheral
  // lines, since that register steers both ranges
  logic lower_acc_r;
  logic peri_acc_r;
  logic mid_base_acc_r;
  logic mid_size_acc_r;

  // output flops
  // every pin leaves from a flop so no select glitches while the decode
  // settles; the price is one cycle of latency on every select
  logic [15:0] reg_rdata_r;
  logic low_sel_n_r;
  logic [3:0] mid_sel_n_r;
  logic [6:0] peri_sel_n_r;
  logic latched_a1_r; // address bit 1 caught at each address phase
  logic latched_a2_r; // address bit 2 caught at each address phase
  logic ready_valid_r;
  logic [2:0] ready_mode_r;
  logic [1:0] wait_states_r;
  logic ext_ready_used_r;

  // decode results for the current address phase
  // combinational hits, turned into pins at the next edge
  logic low_hit;
  logic mid_hit;
  logic [1:0] mid_quarter;
  logic [6:0] peri_hit;
  logic peri_any;
  logic peri_upper;
  logic [2:0] ready_sel;
  logic any_hit;

  // register port strobes
  // reg_sel qualifies every strobe; an unmapped offset touches nothing
  logic acc_lower;
  logic acc_peri;
  logic acc_mid_base;
  logic acc_mid_size;

  // true when the port addresses the register at the given offset
  // one compare shared by all four strobes so the offsets decode alike
  function automatic logic reg_match(input logic [7:0] addr, input logic [7:0] ofs);
    reg_match = (addr == ofs);
  endfunction : reg_match

  // number of wait states carried by a ready field
  // two low bits give 0 to 3 inserted waits, whatever the top bit says
  function automatic logic [1:0] ready_waits(input logic [2:0] field);
    ready_waits = field[1:0];
  endfunction : ready_waits

  // external ready counts unless the top bit of the field is set
  function automatic logic ready_ext(input logic [2:0] field);
    ready_ext = ~field[READY_IGNORE_BIT];
  endfunction : ready_ext

  // a read and a write both count as an access
  assign acc_lower = reg_sel & reg_match(reg_addr, OFS_LOWER_MEMORY_LIMIT);
  assign acc_peri = reg_sel & reg_match(reg_addr, OFS_PERIPHERAL_BASE_READY);
  assign acc_mid_base = reg_sel & reg_match(reg_addr, OFS_MIDRANGE_BASE_READY);
  assign acc_mid_size = reg_sel & reg_match(reg_addr, OFS_MIDRANGE_SIZE_PERIPH_MODE);

  // register writes; only legal patterns are expected, the hardware does not check
  // a write to an unmapped offset is dropped without any answer
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      lower_memory_limit_r <= REG_RESET_VALUE;
      peripheral_base_ready_r <= REG_RESET_VALUE;
      midrange_base_ready_r <= REG_RESET_VALUE;
      midrange_size_periph_mode_r <= REG_RESET_VALUE;
    end else if (reg_wr) begin
      if (acc_lower) begin
        lower_memory_limit_r <= reg_wdata;
      end
      if (acc_peri) begin
        peripheral_base_ready_r <= reg_wdata;
      end
      if (acc_mid_base) begin
        midrange_base_ready_r <= reg_wdata;
      end
      if (acc_mid_size) begin
        midrange_size_periph_mode_r <= reg_wdata;
      end
    end
  end

  // access flags keep each range dark until software has touched its registers
  // flags only ever set; reset alone clears them, so no set/clear race exists
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      lower_acc_r <= 1'b0;
      peri_acc_r <= 1'b0;
      mid_base_acc_r <= 1'b0;
      mid_size_acc_r <= 1'b0;
    end else begin
      if (acc_lower) begin
        lower_acc_r <= 1'b1;
      end
      if (acc_peri) begin
        peri_acc_r <= 1'b1;
      end
      if (acc_mid_base) begin
        mid_base_acc_r <= 1'b1;
      end
      if (acc_mid_size) begin
        mid_size_acc_r <= 1'b1;
      end
    end
  end

  // read data, registered; unmapped offsets answer zero
  // a write leaves the read data alone, so the last read stays visible
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata_r <= 16'h0000;
    end else if (reg_sel && !reg_wr) begin
      if (acc_lower) begin
        reg_rdata_r <= lower_memory_limit_r;
      end else if (acc_peri) begin
        reg_rdata_r <= peripheral_base_ready_r;
      end else if (acc_mid_base) begin
        reg_rdata_r <= midrange_base_ready_r;
      end else if (acc_mid_size) begin
        reg_rdata_r <= midrange_size_periph_mode_r;
      end else begin
        reg_rdata_r <= 16'h0000;
      end
    end
  end

  // lower range: base fixed at zero, so only the upper bound is compared
  // six implied ones sit below the limit, so the smallest block is 1K;
  // an I/O cycle never reaches this range
  always_comb begin
    low_hit = cyc_valid & cyc_is_mem & lower_acc_r
      & (cyc_addr[19:4] <= {lower_memory_limit_r[LOWER_LIMIT_MSB:LOWER_LIMIT_LSB], LOWER_FILL_ONES});
  end

  // mid range: the set size bit decides how many base bits are compared
  // and which two address bits pick the quarter; a bad size field gives
  // the last matching bit, which is as good as any since it is unsupported
  // base bits below the block size are ignored, so a misaligned base
  // simply snaps down to the block boundary
  always_comb begin
    logic [6:0] keep;
    logic [6:0] base;
    mid_hit = 1'b0;
    mid_quarter = 2'b00;
    keep = 7'h00;
    base = midrange_base_ready_r[MID_BASE_MSB:MID_BASE_LSB];
    for (int k = 0; k < MID_SIZE_COUNT; k++) begin
      if (midrange_size_periph_mode_r[MID_SIZE_LSB + k]) begin
        keep = 7'h7F << k;
        mid_quarter = cyc_addr[MID_BLOCK_SHIFT - 1 + k -: 2];
      end
    end
    mid_hit = cyc_valid & cyc_is_mem & mid_base_acc_r & mid_size_acc_r
      & (keep != 7'h00)
      & (((cyc_addr[19:13] ^ base) & keep) == 7'h00);
  end

  // peripheral range: seven 128-byte lines in the 1K window at the base
  // lines five and six count as hits only while they are selects, so a
  // latched address bit never claims a ready field
  generate
    for (genvar n = 0; n < PERI_SELECT_COUNT; n++) begin : g_peri
      always_comb begin
        peri_hit[n] = cyc_valid & peri_acc_r & mid_size_acc_r
          & (cyc_is_mem == midrange_size_periph_mode_r[PERIPH_SPACE_SELECT_BIT])
          & (cyc_addr[19:10] == peripheral_base_ready_r[PERI_BASE_MSB:PERI_BASE_LSB])
          & (cyc_addr[9:7] == 3'(n))
          & (midrange_size_periph_mode_r[EXTEND_SELECT_COUNT_BIT] | (n < PERI_A1_LINE));
      end
    end
  endgenerate

  assign peri_any = |peri_hit;
  assign peri_upper = |peri_hit[6:PERI_UPPER_GROUP];
  assign any_hit = low_hit | mid_hit | peri_any;

  // ready field of the range hit; lower wins over mid, mid over peripheral
  // overlaps are not policed; software keeps ranges apart, and this order
  // only decides which ready field wins when it does not
  always_comb begin
    if (low_hit) begin
      ready_sel = lower_memory_limit_r[READY_MSB:READY_LSB];
    end else if (mid_hit) begin
      ready_sel = midrange_base_ready_r[READY_MSB:READY_LSB];
    end else if (peri_upper) begin
      ready_sel = midrange_size_periph_mode_r[READY_MSB:READY_LSB];
    end else if (peri_any) begin
      ready_sel = peripheral_base_ready_r[READY_MSB:READY_LSB];
    end else begin
      ready_sel = 3'h0;
    end
  end

  // lower select flop, high in reset and between cycles
  // reset drives the select high at once, not at the next edge
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      low_sel_n_r <= 1'b1;
    end else begin
      low_sel_n_r <= ~low_hit;
    end
  end

  // mid-range select flops, one line per quarter
  // each line compares its own quarter index, so at most one line drops
  generate
    for (genvar q = 0; q < MID_SELECT_COUNT; q++) begin : g_mid
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          mid_sel_n_r[q] <= 1'b1;
        end else begin
          mid_sel_n_r[q] <= ~(mid_hit & (mid_quarter == 2'(q)));
        end
      end
    end
  endgenerate

  // latched A1/A2, caught at every address phase like an address latch
  // the latch follows every cycle, selected or not, so the bits match the
  // address the outside peripheral sees
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      latched_a1_r <= 1'b1;
      latched_a2_r <= 1'b1;
    end else if (cyc_valid) begin
      latched_a1_r <= cyc_addr[1];
      latched_a2_r <= cyc_addr[2];
    end
  end

  // peripheral select flops; the two top lines may carry address bits instead
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      peri_sel_n_r <= 7'h7F;
    end else begin
      peri_sel_n_r <= ~peri_hit;
      // the mode bit means nothing until the size register is touched, so
      // lines five and six stay idle like the other peripheral lines till then
      if (mid_size_acc_r && !midrange_size_periph_mode_r[EXTEND_SELECT_COUNT_BIT]) begin
        // address bits show the value caught in this same cycle
        peri_sel_n_r[PERI_A1_LINE] <= cyc_valid ? cyc_addr[1] : latched_a1_r;
        peri_sel_n_r[PERI_A2_LINE] <= cyc_valid ? cyc_addr[2] : latched_a2_r;
      end
    end
  end

  // ready mode outputs for the wait-state generator outside this block
  // they line up with the selects and only carry meaning while
  // ready_valid is high
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ready_valid_r <= 1'b0;
      ready_mode_r <= 3'h0;
      wait_states_r <= 2'h0;
      ext_ready_used_r <= 1'b1;
    end else begin
      ready_valid_r <= any_hit;
      ready_mode_r <= ready_sel;
      wait_states_r <= ready_waits(ready_sel);
      ext_ready_used_r <= ready_ext(ready_sel);
    end
  end

  // every output comes straight from a flop
  // port names stay apart from flop names so the flops keep the _r mark
  assign reg_rdata = reg_rdata_r;
  assign low_mem_select_n = low_sel_n_r;
  assign midrange_select_n = mid_sel_n_r;
  assign peripheral_select_n = peri_sel_n_r;
  assign ready_valid = ready_valid_r;
  assign ready_mode_field = ready_mode_r;
  assign wait_states = wait_states_r;
  assign ext_ready_used = ext_ready_used_r;

endmodule : lower_mid_periph_chip_select

// ---- verification/cs_decode_asserts.sv ----
// port assertions for the lower, mid-range and peripheral select decoder
`timescale 1ns/1ps
module cs_decode_asserts
  import cs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic reg_sel,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic cyc_valid,
  input wire logic cyc_is_mem,
  input wire logic [19:0] cyc_addr,
  input wire logic low_mem_select_n,
  input wire logic [3:0] midrange_select_n,
  input wire logic [6:0] peripheral_select_n,
  input wire logic ready_valid,
  input wire logic [2:0] ready_mode_field
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  logic lo_acc_r, pb_acc_r, mb_acc_r, sz_acc_r; // register touched since reset
  logic [15:0] lo_r; // copy of the lower limit
  logic ex_r; // copy of the extend bit
  // shadow the register port; a read counts as an access too
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      {lo_acc_r, pb_acc_r, mb_acc_r, sz_acc_r, ex_r} <= '0;
      lo_r <= REG_RESET_VALUE;
    end else if (reg_sel) begin
      lo_acc_r <= lo_acc_r | (reg_addr == OFS_LOWER_MEMORY_LIMIT);
      pb_acc_r <= pb_acc_r | (reg_addr == OFS_PERIPHERAL_BASE_READY);
      mb_acc_r <= mb_acc_r | (reg_addr == OFS_MIDRANGE_BASE_READY);
      sz_acc_r <= sz_acc_r | (reg_addr == OFS_MIDRANGE_SIZE_PERIPH_MODE);
      if (reg_wr && reg_addr == OFS_LOWER_MEMORY_LIMIT) lo_r <= reg_wdata;
      if (reg_wr && reg_addr == OFS_MIDRANGE_SIZE_PERIPH_MODE) ex_r <= reg_wdata[EXTEND_SELECT_COUNT_BIT];
    end
  end
  // a memory cycle inside the accessed lower range
  sequence s_lower_hit;
    cyc_valid && cyc_is_mem && lo_acc_r && (cyc_addr[19:4] <= {lo_r[15:6], 6'h3f});
  endsequence
  property p_reset_idle; $rose(arst_n) |-> low_mem_select_n && (&midrange_select_n) && (&peripheral_select_n); endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("select active out of reset");
  property p_low_gate; !lo_acc_r |=> low_mem_select_n; endproperty
  a_low_gate: assert property (p_low_gate)
    else $error("lower select before access");
  property p_mid_gate; !(mb_acc_r && sz_acc_r) |=> &midrange_select_n; endproperty
  a_mid_gate: assert property (p_mid_gate)
    else $error("mid select before access");
  property p_peri_gate; !(pb_acc_r && sz_acc_r) |=> &peripheral_select_n[4:0]; endproperty
  a_peri_gate: assert property (p_peri_gate)
    else $error("peripheral select before access");
  property p_io_no_mem; cyc_valid && !cyc_is_mem |=> low_mem_select_n && (&midrange_select_n); endproperty
  a_io_no_mem: assert property (p_io_no_mem)
    else $error("memory select on an io cycle");
  property p_lower_hit; s_lower_hit |=> !low_mem_select_n && ready_valid && ready_mode_field == $past(lo_r[2:0]); endproperty
  a_lower_hit: assert property (p_lower_hit)
    else $error("lower hit wrong");
  property p_latch_a12; sz_acc_r && !ex_r && cyc_valid |=> peripheral_select_n[6:5] == $past(cyc_addr[2:1]); endproperty
  a_latch_a12: assert property (p_latch_a12)
    else $error("latched address bits wrong");
  property p_one_line; $onehot0(~midrange_select_n) && $onehot0(~peripheral_select_n[4:0]); endproperty
  a_one_line: assert property (p_one_line)
    else $error("two lines of one group active");
endmodule : cs_decode_asserts

// ---- verification/select_target_bank.sv ----
// model of the memories and peripheral chips behind the select lines
`timescale 1ns/1ps
module select_target_bank (
  input wire logic low_mem_select_n,
  input wire logic [3:0] midrange_select_n,
  input wire logic [6:0] peripheral_select_n,
  output logic [3:0] n_sel
);
  // each chip listens while its line is low; count how many answer
  always_comb begin
    n_sel = 4'($countones(~{low_mem_select_n, midrange_select_n, peripheral_select_n}));
  end
endmodule : select_target_bank

// ---- verification/testbench.sv ----
// self-checking bench for the select decoder
`timescale 1ns/1ps
module testbench
  import cs_pkg::*;
;
  logic ref_clk = 1'b0, arst_n = 1'b0, reg_sel = 1'b0, reg_wr = 1'b0, cyc_valid = 1'b0, cyc_is_mem = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [19:0] cyc_addr = 20'h0_0000;
  logic low_mem_select_n, ready_valid, ext_ready_used;
  logic [3:0] midrange_select_n, n_sel;
  logic [6:0] peripheral_select_n;
  logic [2:0] ready_mode_field;
  logic [1:0] wait_states;
  logic [15:0] rg[4]; // mirrors: lower, peripheral base, mid base, mid size
  logic ok[4]; // register touched since reset
  int n_fail = 0;
  int num_checks = 0;
  always #5 ref_clk = ~ref_clk;
  lower_mid_periph_chip_select u_dut (.ref_clk, .arst_n, .reg_sel, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
    .cyc_valid, .cyc_is_mem, .cyc_addr, .low_mem_select_n, .midrange_select_n, .peripheral_select_n,
    .ready_valid, .ready_mode_field, .wait_states, .ext_ready_used);
  select_target_bank u_bank (.low_mem_select_n, .midrange_select_n, .peripheral_select_n, .n_sel);
  // verdict, also reached by the watchdog
  task automatic results;
    if (n_fail == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask : check
  // hold reset twelve cycles; mirrors forget every access
  task automatic do_reset;
    arst_n = 1'b0;
    reg_sel = 1'b0;
    cyc_valid = 1'b0;
    foreach (rg[i]) begin
      rg[i] = REG_RESET_VALUE;
      ok[i] = 1'b0;
    end
    repeat (12) @(negedge ref_clk);
    check({low_mem_select_n, midrange_select_n, peripheral_select_n}, 12'hfff);
    arst_n = 1'b1;
  endtask : do_reset
  // one register access; read data is looked at after its edge
  // reg_sel stays up afterwards; the next task reuses or lowers it
  task automatic reg_acc(logic wr, logic [7:0] ofs, logic [15:0] d, logic [15:0] exp);
    reg_sel = 1'b1;
    reg_wr = wr;
    reg_addr = ofs;
    reg_wdata = d;
    cyc_valid = 1'b0;
    @(negedge ref_clk);
    if (!wr) check(32'(reg_rdata), 32'(exp));
    for (int j = 0; j < 4; j++) begin
      if (ofs == 8'(OFS_LOWER_MEMORY_LIMIT + 2 * j)) begin
        ok[j] = 1'b1;
        if (wr) rg[j] = d;
      end
    end
  endtask : reg_acc
  // expected outputs; later hits override, so lower wins ready
  function automatic logic [18:0] exp_out(logic m, logic [19:0] a);
    logic [6:0] p = '1;
    logic [3:0] q = '1;
    logic l = 1'b1, hv = 1'b0;
    logic [2:0] rm = 3'h0;
    int k = -1;
    for (int i = 0; i < 7; i++) if (rg[3][8 + i]) k = i;
    if (ok[1] && ok[3] && m == rg[3][6] && a[19:10] == rg[1][15:6] && a[9:7] < 7 && (rg[3][7] || a[9:7] < 5)) begin
      p[a[9:7]] = 1'b0;
      hv = 1'b1;
      rm = (a[9:7] > 3) ? rg[3][2:0] : rg[1][2:0];
    end
    if (ok[3] && !rg[3][7]) p[6:5] = a[2:1];
    if (ok[2] && ok[3] && m && k >= 0 && (a[19:13] >> k) == (rg[2][15:9] >> k)) begin
      q[(a >> (11 + k)) & 20'h3] = 1'b0;
      hv = 1'b1;
      rm = rg[2][2:0];
    end
    if (ok[0] && m && a[19:4] <= {rg[0][15:6], 6'h3f}) begin
      l = 1'b0;
      hv = 1'b1;
      rm = rg[0][2:0];
    end
    return {hv, rm, rm[1:0], ~rm[2], p, q, l};
  endfunction : exp_out
  // one bus cycle: the next edge decodes it, the next fall compares
  task automatic do_cyc(logic m, logic [19:0] a);
    logic [18:0] e;
    reg_sel = 1'b0;
    cyc_valid = 1'b1;
    cyc_is_mem = m;
    cyc_addr = a;
    e = exp_out(m, a);
    @(negedge ref_clk);
    check({ready_valid, ready_mode_field, wait_states, ext_ready_used, peripheral_select_n, midrange_select_n,
      low_mem_select_n}, 32'(e));
    check(32'(n_sel), $countones(~e[11:0]));
  endtask : do_cyc
  initial begin
    int k;
    logic [15:0] v;
    logic [19:0] a;
    void'($urandom(32'h0f67_e635));
    do_reset;
    // random address bits: lines five and six stay idle before any access too
    repeat (4) do_cyc(1'($urandom), 20'($urandom));
    for (int j = 0; j < 4; j++) reg_acc(1'b0, 8'(OFS_LOWER_MEMORY_LIMIT + 2 * j), 16'h0000, REG_RESET_VALUE);
    do_cyc(1'b1, 20'h0_03ff);
    do_cyc(1'b1, 20'h0_0400);
    do_cyc(1'b0, 20'h0_0100);
    // sweep sizes, lower patterns, space and extend modes
    for (int j = 0; j < 28; j++) begin
      k = j % 7;
      // a 512K block sits at zero with the lower range unprogrammed; reset on entry and exit
      if (k == 0 || k == 6) do_reset;
      if (k != 6) reg_acc(1'b1, OFS_LOWER_MEMORY_LIMIT,
        16'((((1 << (j % 9)) - 1) << 6) | 'h38 | $urandom_range(0, 7)), 16'h0000);
      v = 16'($urandom) & (j % 14 < 7 ? 16'h0fff : 16'hffff);
      reg_acc(1'b1, OFS_PERIPHERAL_BASE_READY, v, 16'h0000);
      v = 16'($urandom);
      v[15:9] = (k == 6) ? 7'h00 : v[15:9] & ~7'((1 << k) - 1);
      reg_acc(1'b1, OFS_MIDRANGE_BASE_READY, v, 16'h0000);
      v = 16'((1 << (8 + k)) | ((j / 14) << 7) | ((j % 14 / 7) << 6) | $urandom_range(0, 7));
      reg_acc(1'b1, OFS_MIDRANGE_SIZE_PERIPH_MODE, v, 16'h0000);
      repeat (12) begin
        case ($urandom_range(0, 3))
          0: a = {rg[0][15:6], 10'h3ff} + 20'($urandom_range(0, 1));
          1: a = {rg[2][15:9], 13'h0000} + 20'($urandom_range(0, (16384 << k) - 1));
          2: a = {rg[1][15:6], 10'($urandom)};
          default: a = 20'($urandom);
        endcase
        do_cyc(1'($urandom), a);
      end
    end
    // read back every register, size first so every step stays legal, then an unmapped place
    for (int j = 3; j >= 0; j--) begin
      v = 16'($urandom);
      if (j == 3) v[14:6] = {7'h01, v[7], 1'b1};
      if (j == 0) v[15:3] = 13'h07ff;
      reg_acc(1'b1, 8'(OFS_LOWER_MEMORY_LIMIT + 2 * j), v, 16'h0000);
      reg_acc(1'b0, 8'(OFS_LOWER_MEMORY_LIMIT + 2 * j), 16'h0000, v);
    end
    reg_acc(1'b1, 8'haa, 16'h1234, 16'h0000);
    reg_acc(1'b0, 8'haa, 16'h0000, 16'h0000);
    // final reset must forget the accesses
    do_reset;
    do_cyc(1'b1, 20'h0_0006);
    results;
  end
  // watchdog far beyond the roughly six hundred cycles of the run
  initial begin
    #100_000;
    n_fail++;
    results;
  end
endmodule : testbench
bind lower_mid_periph_chip_select cs_decode_asserts u_chk (.ref_clk, .arst_n, .reg_sel, .reg_wr, .reg_addr,
  .reg_wdata, .cyc_valid, .cyc_is_mem, .cyc_addr, .low_mem_select_n, .midrange_select_n, .peripheral_select_n,
  .ready_valid, .ready_mode_field);
